// >>> src/ubc_pkg.sv
// constants, encodings and state types for the usb boost configuration block
package ubc_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int SHUT_MIN_NS = 20000;
   localparam int SHUT_CYC = (SHUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SAMPLE_DELAY_NS = 1000;
   localparam int SAMPLE_CYC = (SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 10;

   // i2c target address and register offsets
   localparam logic [6:0] I2C_ADDR = 7'h2c;
   localparam logic [7:0] OFS_AC_BOOST = 8'h01;
   localparam logic [7:0] OFS_CFG_HOLD = 8'h03;
   localparam logic [7:0] OFS_DC_GAIN_STRAP = 8'h0e;

   // field positions
   localparam int AC_LSB = 4;
   localparam int AC_MSB = 6;
   localparam int HOLD_BIT = 0;
   localparam int DC_LSB = 0;
   localparam int DC_MSB = 2;

   // field encodings and reset values
   localparam logic [2:0] AC_LVL0 = 3'h0;
   localparam logic [2:0] AC_LVL1 = 3'h1;
   localparam logic [2:0] AC_LVL2 = 3'h3;
   localparam logic [2:0] AC_LVL3 = 3'h7;
   localparam logic [2:0] DC_40MV = 3'h3;
   localparam logic [2:0] DC_60MV = 3'h5;
   localparam logic [2:0] DC_80MV = 3'h7;
   localparam logic HOLD_RESET = 1'b1;

   // tri-level dc strap as seen from the input comparators
   localparam logic [1:0] DC_STRAP_LOW = 2'h0;
   localparam logic [1:0] DC_STRAP_MID = 2'h1;
   localparam logic [1:0] DC_STRAP_HIGH = 2'h2;

   // connection speed codes
   typedef enum logic [1:0] {
      SPD_NONE = 2'h0,
      SPD_LS = 2'h1,
      SPD_FS = 2'h2,
      SPD_HS = 2'h3
   } ubc_speed_t;

   // top-level phase
   typedef enum logic [2:0] {
      PH_OFF = 3'h1,
      PH_SAMPLE = 3'h2,
      PH_RUN = 3'h4
   } ubc_phase_t;

   // i2c target states
   typedef enum logic [6:0] {
      I2_IDLE = 7'h01,
      I2_ADDR = 7'h02,
      I2_ACK = 7'h04,
      I2_REG = 7'h08,
      I2_WR = 7'h10,
      I2_RD = 7'h20,
      I2_RACK = 7'h40
   } ubc_i2c_state_t;
endpackage : ubc_pkg

// >>> src/ubc_i2c_target.sv
// i2c target byte engine, oversampling synchronised scl and sda
module ubc_i2c_target (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_clock_en,
   // mode and synchronised pins
   input wire logic i_enable,
   input wire logic i_scl,
   input wire logic i_sda,
   // register access
   input wire logic [7:0] i_rd_data,
   output logic [7:0] o_ptr,
   output logic [7:0] o_wr_data,
   output logic o_wr_strobe,
   output logic o_sda_oe
);
   typedef struct packed {
      logic [6:0] state;
      logic [6:0] next;
      logic [7:0] shift;
      logic [3:0] cnt;
      logic [7:0] ptr;
      logic [7:0] wdata;
      logic wr;
      logic drive;
      logic scl_prev;
      logic sda_prev;
   } ubc_i2c_regs_t;

   ubc_i2c_regs_t q;
   ubc_i2c_regs_t d;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   // bus condition decode
   assign scl_rise = i_scl & ~q.scl_prev;
   assign scl_fall = ~i_scl & q.scl_prev;
   assign start_c = i_scl & q.scl_prev & q.sda_prev & ~i_sda;
   assign stop_c = i_scl & q.scl_prev & ~q.sda_prev & i_sda;

   // next state
   always_comb
   begin
      d = q;
      d.scl_prev = i_scl;
      d.sda_prev = i_sda;
      d.wr = 1'b0;
      if (!i_enable || stop_c)
      begin
         d.state = ubc_pkg::I2_IDLE;
         d.drive = 1'b0;
      end
      else if (start_c)
      begin
         d.state = ubc_pkg::I2_ADDR;
         d.cnt = 4'h0;
         d.drive = 1'b0;
      end
      else if (scl_rise)
      begin
         case (q.state)
            ubc_pkg::I2_ADDR, ubc_pkg::I2_REG, ubc_pkg::I2_WR:
            begin
               d.shift = {q.shift[6:0], i_sda};
               d.cnt = q.cnt + 4'h1;
            end
            ubc_pkg::I2_RACK:
            begin
               if (i_sda)
                  d.state = ubc_pkg::I2_IDLE; // host nack ends the read
            end
            default:
            begin
               d.cnt = q.cnt;
            end
         endcase
      end
      else if (scl_fall)
      begin
         case (q.state)
            ubc_pkg::I2_ADDR:
            begin
               if (q.cnt == 4'h8 && q.shift[7:1] == ubc_pkg::I2C_ADDR)
               begin
                  d.drive = 1'b1;
                  d.state = ubc_pkg::I2_ACK;
                  d.next = q.shift[0] ? ubc_pkg::I2_RD : ubc_pkg::I2_REG;
               end
               else if (q.cnt == 4'h8)
                  d.state = ubc_pkg::I2_IDLE;
            end
            ubc_pkg::I2_REG:
            begin
               if (q.cnt == 4'h8)
               begin
                  d.ptr = q.shift;
                  d.drive = 1'b1;
                  d.state = ubc_pkg::I2_ACK;
                  d.next = ubc_pkg::I2_WR;
               end
            end
            ubc_pkg::I2_WR:
            begin
               if (q.cnt == 4'h8)
               begin
                  d.wdata = q.shift;
                  d.wr = 1'b1;
                  d.drive = 1'b1;
                  d.state = ubc_pkg::I2_ACK;
                  d.next = ubc_pkg::I2_WR;
               end
            end
            ubc_pkg::I2_ACK, ubc_pkg::I2_RACK:
            begin
               d.cnt = 4'h0;
               d.drive = 1'b0;
               d.state = q.next;
               if (q.next == ubc_pkg::I2_RD || q.state == ubc_pkg::I2_RACK)
               begin
                  // load and present the first bit of the read byte
                  d.state = ubc_pkg::I2_RD;
                  d.drive = ~i_rd_data[7];
                  d.shift = {i_rd_data[6:0], 1'b0};
                  d.cnt = 4'h1;
                  d.ptr = q.ptr + 8'h01;
               end
               if (q.state == ubc_pkg::I2_ACK && q.next == ubc_pkg::I2_WR && q.wr == 1'b0 && q.cnt == 4'h8)
                  d.ptr = q.ptr;
            end
            ubc_pkg::I2_RD:
            begin
               if (q.cnt == 4'h8)
               begin
                  d.drive = 1'b0;
                  d.state = ubc_pkg::I2_RACK;
               end
               else
               begin
                  d.drive = ~q.shift[7];
                  d.shift = {q.shift[6:0], 1'b0};
                  d.cnt = q.cnt + 4'h1;
               end
            end
            default:
            begin
               d.drive = 1'b0;
            end
         endcase
      end
      if (q.wr)
         d.ptr = q.ptr + 8'h01; // auto-increment after each written byte
   end

   // state register
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         q <= '0;
         q.state <= ubc_pkg::I2_IDLE;
         q.next <= ubc_pkg::I2_IDLE;
         q.scl_prev <= 1'b1;
         q.sda_prev <= 1'b1;
      end
      else if (i_clock_en)
         q <= d;
   end

   assign o_ptr = q.ptr;
   assign o_wr_data = q.wdata;
   assign o_wr_strobe = q.wr;
   assign o_sda_oe = q.drive;
endmodule : ubc_i2c_target

// >>> src/ubc_config_control.sv
// usb boost configuration, strap latch, i2c registers and connection mode control
// How it works
// - shutdown low recognised only after 20 us
// - dc strap low/mid/high gives 40/60/80 mV
// - ac strap resistor selects one of four
// - low speed: no compensation, detect high
// - full speed: no compensation, detect high
// - high speed: compensation on, detect high
// - shutdown: no compensation, no detect output
// - i2c enabled when both lines sampled high
// - i2c target answers at address 0x2c
// - ac field bits 6:4, strap loaded
// - hold resets set, auto-clears without i2c
// - dc field bits 2:0, strap loaded
// - straps latched only at reset release and at each shutdown release
module ubc_config_control (
   // system clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_clock_en,
   // link clock and speed indicators from the line receiver
   input wire logic i_link_clock,
   input wire logic i_ls_seen,
   input wire logic i_fs_seen,
   input wire logic i_hs_seen,
   // pins: shutdown and straps
   input wire logic i_shutdown_n_input,
   input wire logic [1:0] i_ac_boost_strap,
   input wire logic [1:0] i_dc_gain_strap,
   // pins: i2c
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // mode outputs
   output logic o_connection_detect_out,
   output logic o_compensation_en,
   output logic [2:0] o_ac_boost_level_field,
   output logic [2:0] o_dc_gain_strap_level_field,
   output logic [1:0] o_speed,
   output logic o_i2c_mode,
   output logic o_configuration_hold
);
   typedef struct packed {
      logic [1:0] sd_sync;
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic [3:0] ac_sync;
      logic [3:0] dc_sync;
      logic [2:0] tog_sync;
      logic [ubc_pkg::CNT_W-1:0] cnt;
      logic shut;
      ubc_pkg::ubc_phase_t phase;
      logic i2c_mode;
      logic [2:0] ac;
      logic [2:0] dc;
      logic hold;
      ubc_pkg::ubc_speed_t speed;
      logic run;
      logic cd;
      logic comp;
   } ubc_main_regs_t;

   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] run_sync;
      logic [1:0] en_sync;
      ubc_pkg::ubc_speed_t speed;
      logic tog;
   } ubc_link_regs_t;

   ubc_main_regs_t q;
   ubc_main_regs_t d;
   ubc_link_regs_t lq;
   ubc_link_regs_t ld;
   logic [7:0] rd_data;
   logic [7:0] ptr;
   logic [7:0] wr_data;
   logic wr_strobe;
   logic sda_oe;
   logic sd_low;
   logic [2:0] ac_code;
   logic [2:0] dc_code;

   // i2c byte engine
   ubc_i2c_target u_i2c (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_clock_en(i_clock_en),
      .i_enable(q.i2c_mode && q.phase == ubc_pkg::PH_RUN),
      .i_scl(q.scl_sync[1]),
      .i_sda(q.sda_sync[1]),
      .i_rd_data(rd_data),
      .o_ptr(ptr),
      .o_wr_data(wr_data),
      .o_wr_strobe(wr_strobe),
      .o_sda_oe(sda_oe)
   );

   // register read mux, reserved bits read zero
   always_comb
   begin
      rd_data = 8'h00;
      case (ptr)
         ubc_pkg::OFS_AC_BOOST: rd_data[ubc_pkg::AC_MSB:ubc_pkg::AC_LSB] = q.ac;
         ubc_pkg::OFS_CFG_HOLD: rd_data[ubc_pkg::HOLD_BIT] = q.hold;
         ubc_pkg::OFS_DC_GAIN_STRAP: rd_data[ubc_pkg::DC_MSB:ubc_pkg::DC_LSB] = q.dc;
         default: rd_data = 8'h00;
      endcase
   end

   // strap decode from the synchronised levels
   always_comb
   begin
      case (q.ac_sync[3:2])
         2'h0: ac_code = ubc_pkg::AC_LVL0;
         2'h1: ac_code = ubc_pkg::AC_LVL1;
         2'h2: ac_code = ubc_pkg::AC_LVL2;
         default: ac_code = ubc_pkg::AC_LVL3;
      endcase
      case (q.dc_sync[3:2])
         ubc_pkg::DC_STRAP_LOW: dc_code = ubc_pkg::DC_40MV;
         ubc_pkg::DC_STRAP_HIGH: dc_code = ubc_pkg::DC_80MV;
         ubc_pkg::DC_STRAP_MID: dc_code = ubc_pkg::DC_60MV;
         default: dc_code = ubc_pkg::DC_60MV;
      endcase
   end

   assign sd_low = ~q.sd_sync[1];

   // main domain next state
   always_comb
   begin
      d = q;
      d.sd_sync = {q.sd_sync[0], i_shutdown_n_input};
      d.scl_sync = {q.scl_sync[0], i_scl};
      d.sda_sync = {q.sda_sync[0], i_sda};
      d.ac_sync = {q.ac_sync[1:0], i_ac_boost_strap};
      d.dc_sync = {q.dc_sync[1:0], i_dc_gain_strap};
      d.tog_sync = {q.tog_sync[1:0], lq.tog};
      // speed word captured once its toggle has crossed
      if (q.tog_sync[2] != q.tog_sync[1])
         d.speed = lq.speed;
      // low pulse must persist before it counts as shutdown
      if (sd_low && !q.shut)
      begin
         d.cnt = q.cnt + 1'b1;
         if (q.cnt == ubc_pkg::CNT_W'(ubc_pkg::SHUT_CYC - 1))
         begin
            d.shut = 1'b1;
            d.phase = ubc_pkg::PH_OFF;
         end
      end
      else if (!sd_low && q.phase != ubc_pkg::PH_SAMPLE)
         d.cnt = '0;
      case (q.phase)
         ubc_pkg::PH_OFF:
         begin
            if (!sd_low)
            begin
               d.shut = 1'b0;
               d.cnt = '0;
               d.phase = ubc_pkg::PH_SAMPLE;
            end
         end
         ubc_pkg::PH_SAMPLE:
         begin
            if (sd_low)
               d.cnt = q.cnt;
            else if (q.cnt == ubc_pkg::CNT_W'(ubc_pkg::SAMPLE_CYC - 1))
            begin
               // latch straps and mode once, after release
               d.ac = ac_code;
               d.dc = dc_code;
               d.i2c_mode = q.scl_sync[1] & q.sda_sync[1];
               d.hold = q.scl_sync[1] & q.sda_sync[1];
               d.cnt = '0;
               d.phase = ubc_pkg::PH_RUN;
            end
            else
               d.cnt = q.cnt + 1'b1;
         end
         ubc_pkg::PH_RUN:
         begin
            if (wr_strobe)
            begin
               case (ptr)
                  ubc_pkg::OFS_AC_BOOST: d.ac = wr_data[ubc_pkg::AC_MSB:ubc_pkg::AC_LSB];
                  ubc_pkg::OFS_CFG_HOLD: d.hold = wr_data[ubc_pkg::HOLD_BIT];
                  ubc_pkg::OFS_DC_GAIN_STRAP: d.dc = wr_data[ubc_pkg::DC_MSB:ubc_pkg::DC_LSB];
                  default: d.hold = q.hold;
               endcase
            end
         end
         default:
         begin
            d.phase = ubc_pkg::PH_OFF;
         end
      endcase
      if (d.phase == ubc_pkg::PH_OFF)
         d.hold = ubc_pkg::HOLD_RESET;
      // detection runs only when configured and not held
      d.run = (q.phase == ubc_pkg::PH_RUN) && !q.hold;
      d.cd = q.run && !q.shut && q.speed != ubc_pkg::SPD_NONE;
      d.comp = q.run && !q.shut && q.speed == ubc_pkg::SPD_HS;
   end

   // main domain register
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         q <= '0;
         q.sd_sync <= 2'h3;
         q.phase <= ubc_pkg::PH_SAMPLE;
         q.ac <= ubc_pkg::AC_LVL0;
         q.dc <= ubc_pkg::DC_60MV;
         q.hold <= ubc_pkg::HOLD_RESET;
         q.speed <= ubc_pkg::SPD_NONE;
      end
      else if (i_clock_en)
         q <= d;
   end

   // link domain next state: classify the connection speed
   always_comb
   begin
      ld = lq;
      ld.rst_sync = {lq.rst_sync[0], i_resetn};
      ld.run_sync = {lq.run_sync[0], q.run};
      ld.en_sync = {lq.en_sync[0], i_clock_en};
      if (lq.en_sync[1])
      begin
         if (!lq.run_sync[1])
            ld.speed = ubc_pkg::SPD_NONE;
         else if (i_hs_seen)
            ld.speed = ubc_pkg::SPD_HS;
         else if (i_fs_seen)
            ld.speed = ubc_pkg::SPD_FS;
         else if (i_ls_seen)
            ld.speed = ubc_pkg::SPD_LS;
         if (ld.speed != lq.speed)
            ld.tog = ~lq.tog;
      end
   end

   // link domain register
   always_ff @(posedge i_link_clock)
   begin
      if (!lq.rst_sync[1])
      begin
         lq.rst_sync <= ld.rst_sync;
         lq.run_sync <= 2'h0;
         lq.en_sync <= 2'h0;
         lq.speed <= ubc_pkg::SPD_NONE;
         lq.tog <= 1'b0; // known level, matches the main-side sync reset
      end
      else
         lq <= ld;
   end

   // outputs straight from flip-flops, except o_sda_out tied low
   assign o_sda_out = 1'b0;
   assign o_sda_oe = sda_oe;
   assign o_connection_detect_out = q.cd;
   assign o_compensation_en = q.comp;
   assign o_ac_boost_level_field = q.ac;
   assign o_dc_gain_strap_level_field = q.dc;
   assign o_speed = q.speed;
   assign o_i2c_mode = q.i2c_mode;
   assign o_configuration_hold = q.hold;
endmodule : ubc_config_control

// >>> bench/ubc_i2c_host.sv
// i2c host controller model on the open-drain bus at 100 kHz
module ubc_i2c_host (
   // clock and bus
   input wire logic i_clock,
   input wire logic i_sda,
   output logic o_scl_low,
   output logic o_sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int QTR = 63; // quarter bit, keeps the bus just under 100 kHz

   // bus released at start
   initial
   begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end

   // quarter-bit waits on the falling edge
   task automatic qwait(input int n);
      repeat (n * QTR) @(negedge i_clock);
   endtask : qwait

   // start or repeated start, leaves scl low
   task automatic start_cond();
      o_sda_low = 1'b0;
      qwait(1);
      o_scl_low = 1'b0;
      qwait(1);
      o_sda_low = 1'b1;
      qwait(1);
      o_scl_low = 1'b1;
      qwait(1);
   endtask : start_cond

   // stop: sda rises while scl is high
   task automatic stop_cond();
      o_sda_low = 1'b1;
      qwait(1);
      o_scl_low = 1'b0;
      qwait(1);
      o_sda_low = 1'b0;
      qwait(1);
   endtask : stop_cond

   // nine clocks msb first, sda only moves while scl is low
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
      begin
         o_sda_low = ~tx[i];
         qwait(1);
         o_scl_low = 1'b0;
         qwait(1);
         rx[i] = i_sda;
         qwait(1);
         o_scl_low = 1'b1;
         qwait(1);
      end
   endtask : xfer

   // register write: address, pointer, one data byte
   task automatic wr(input logic [6:0] adr, input logic [7:0] ofs, input logic [7:0] dat, output logic ok);
      logic [8:0] r0, r1, r2;
      start_cond();
      xfer({adr, 1'b0, 1'b1}, r0);
      xfer({ofs, 1'b1}, r1);
      xfer({dat, 1'b1}, r2);
      stop_cond();
      ok = ~(r0[0] | r1[0] | r2[0]);
   endtask : wr

   // register read through a repeated start, last byte refused
   task automatic rd(input logic [6:0] adr, input logic [7:0] ofs, output logic [7:0] dat, output logic ok);
      logic [8:0] r0, r1, r2, r3;
      start_cond();
      xfer({adr, 1'b0, 1'b1}, r0);
      xfer({ofs, 1'b1}, r1);
      start_cond();
      xfer({adr, 1'b1, 1'b1}, r2);
      xfer(9'h1ff, r3);
      stop_cond();
      dat = r3[8:1];
      ok = ~(r0[0] | r1[0] | r2[0]);
   endtask : rd
endmodule : ubc_i2c_host

// >>> bench/ubc_config_control_monitor.sv
// port checker for the usb boost configuration block
module ubc_config_control_monitor (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_resetn,
   // watched pins and outputs
   input wire logic i_shutdown_n_input,
   input wire logic o_sda_oe,
   input wire logic o_connection_detect_out,
   input wire logic o_compensation_en,
   input wire logic [2:0] o_ac_boost_level_field,
   input wire logic [2:0] o_dc_gain_strap_level_field,
   input wire logic [1:0] o_speed,
   input wire logic o_i2c_mode,
   input wire logic o_configuration_hold
);
   logic [9:0] low_q;
   logic [9:0] high_q;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   // saturating run lengths of the shutdown pin low and high
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn || i_shutdown_n_input)
         low_q <= 10'h0;
      else if (low_q != 10'h3ff)
         low_q <= low_q + 10'h1;
      if (!i_resetn || !i_shutdown_n_input)
         high_q <= 10'h0;
      else if (high_q != 10'h3ff)
         high_q <= high_q + 10'h1;
   end

   a_reset_values: assert property (disable iff (1'b0) !i_resetn |=> o_configuration_hold && !o_i2c_mode
      && o_dc_gain_strap_level_field == ubc_pkg::DC_60MV && !o_connection_detect_out) else $error("reset values");
   a_comp_only_hs: assert property (o_compensation_en |-> o_speed == ubc_pkg::SPD_HS
      || $past(o_speed) == ubc_pkg::SPD_HS) else $error("compensation without high speed");
   a_cd_with_speed: assert property ((o_speed != ubc_pkg::SPD_NONE && !o_configuration_hold) [*4]
      |-> o_connection_detect_out) else $error("detect missing");
   a_hold_idles: assert property (o_configuration_hold [*4]
      |-> !o_connection_detect_out && !o_compensation_en) else $error("active while held");
   a_long_low_shuts: assert property (low_q > 10'h1fa
      |-> o_configuration_hold && !o_connection_detect_out) else $error("no shutdown");
   a_short_low_kept: assert property (!i_shutdown_n_input && low_q < 10'h1ef && !$past(o_configuration_hold)
      |-> !o_configuration_hold) else $error("short low taken");
   a_fields_latched: assert property (!o_i2c_mode && ($changed(o_ac_boost_level_field)
      || $changed(o_dc_gain_strap_level_field)) |-> high_q < 10'h28) else $error("strap change taken");
   a_strap_hold_clears: assert property (high_q > 10'h28 && !o_i2c_mode
      |-> !o_configuration_hold) else $error("hold stuck");

   // main scenarios reached
   c_comp: cover property (o_compensation_en);
   c_ack: cover property (o_sda_oe);
   c_release: cover property ($fell(o_configuration_hold) && o_i2c_mode);
endmodule : ubc_config_control_monitor

bind ubc_config_control ubc_config_control_monitor i_mon (.i_clock(i_clock), .i_resetn(i_resetn),
   .i_shutdown_n_input(i_shutdown_n_input), .o_sda_oe(o_sda_oe), .o_connection_detect_out(o_connection_detect_out),
   .o_compensation_en(o_compensation_en), .o_ac_boost_level_field(o_ac_boost_level_field),
   .o_dc_gain_strap_level_field(o_dc_gain_strap_level_field), .o_speed(o_speed), .o_i2c_mode(o_i2c_mode),
   .o_configuration_hold(o_configuration_hold));

// >>> bench/ubc_config_control_test.sv
// self-checking bench for the usb boost configuration block
module ubc_config_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, link_clock, resetn, shut_n, ls, fs, hs, scl_park, host_scl, host_sda, ok;
   logic sda_out, sda_oe, cd, comp, i2c_mode, hold;
   logic [1:0] ac_strap, dc_strap, speed;
   logic [2:0] ac_f, dc_f;
   logic [7:0] d;
   logic [2:0] ac_tab [4] = '{ubc_pkg::AC_LVL0, ubc_pkg::AC_LVL1, ubc_pkg::AC_LVL2, ubc_pkg::AC_LVL3};
   logic [2:0] dc_tab [4] = '{ubc_pkg::DC_40MV, ubc_pkg::DC_60MV, ubc_pkg::DC_80MV, ubc_pkg::DC_60MV};
   int err_count = 0;
   int check_count = 0;
   // open-drain lines with pull-ups
   wire logic scl = !(host_scl || scl_park);
   wire logic sda = !(host_sda || sda_oe);

   // system clock and an unrelated link clock
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial
   begin
      link_clock = 1'b0;
      #13;
      forever #80 link_clock = ~link_clock;
   end

   ubc_config_control i_dut (.i_clock(clock), .i_resetn(resetn), .i_clock_en(1'b1), .i_link_clock(link_clock),
      .i_ls_seen(ls), .i_fs_seen(fs), .i_hs_seen(hs), .i_shutdown_n_input(shut_n), .i_ac_boost_strap(ac_strap),
      .i_dc_gain_strap(dc_strap), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .o_connection_detect_out(cd), .o_compensation_en(comp), .o_ac_boost_level_field(ac_f),
      .o_dc_gain_strap_level_field(dc_f), .o_speed(speed), .o_i2c_mode(i2c_mode), .o_configuration_hold(hold));
   ubc_i2c_host i_host (.i_clock(clock), .i_sda(sda), .o_scl_low(host_scl), .o_sda_low(host_sda));

   // verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   // compare and report
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // falling-edge waits
   task automatic wait_c(input int n);
      repeat (n) @(negedge clock);
   endtask : wait_c

   // shutdown pulse of n cycles, detect output sampled before release
   task automatic shut(input int n, input logic exp_cd);
      shut_n = 1'b0;
      wait_c(n);
      check(8'(cd), 8'(exp_cd), "detect in pulse");
      shut_n = 1'b1;
      wait_c(60);
   endtask : shut

   // speed indicators on the link clock, then compare mode outputs
   task automatic speed_case(input logic [2:0] lfh, input logic [7:0] exp);
      @(negedge link_clock);
      {ls, fs, hs} = lfh;
      repeat (8) @(negedge link_clock);
      wait_c(12);
      check(8'({cd, comp, speed}), exp, "mode outputs");
   endtask : speed_case

   // watchdog
   initial
   begin
      #3600000;
      err_count++;
      $display("unexpected at %0t: watchdog", $time);
      tally_and_finish();
   end

   // main sequence
   initial
   begin
      resetn = 1'b0;
      shut_n = 1'b1;
      {ls, fs, hs} = 3'h0;
      ac_strap = 2'h0;
      dc_strap = 2'h0;
      scl_park = 1'b1;
      wait_c(4);
      resetn = 1'b1;
      wait_c(60);
      speed_case(3'h1, 8'h0f);
      speed_case(3'h2, 8'h0a);
      speed_case(3'h4, 8'h09);
      speed_case(3'h1, 8'h0f);
      shut(400, 1'b1);
      $display("test speed done");
      for (int k = 0; k < 4; k++)
      begin
         ac_strap = 2'(k);
         dc_strap = 2'(k);
         shut(520, 1'b0);
         check(8'({ac_f, dc_f, hold, i2c_mode}), 8'({ac_tab[k], dc_tab[k], 2'b00}), "strap fields");
         ac_strap = ~ac_strap;
         dc_strap = 2'(k + 1);
         wait_c(20);
         check(8'({ac_f, dc_f}), 8'({ac_tab[k], dc_tab[k]}), "after strap move");
      end
      $display("test straps done");
      scl_park = 1'b0;
      ac_strap = 2'h2;
      shut(520, 1'b0);
      check(8'({i2c_mode, hold, cd, comp, sda_out}), 8'h18, "i2c entry");
      wait_c(50);
      i_host.wr(7'h2d, ubc_pkg::OFS_CFG_HOLD, 8'h00, ok);
      check(8'({ok, hold}), 8'h01, "foreign address");
      i_host.rd(ubc_pkg::I2C_ADDR, ubc_pkg::OFS_AC_BOOST, d, ok);
      check(d, {1'b0, ubc_pkg::AC_LVL2, 4'h0}, "ac read");
      d[6:4] = ubc_pkg::AC_LVL3;
      i_host.wr(ubc_pkg::I2C_ADDR, ubc_pkg::OFS_AC_BOOST, d, ok);
      check(8'({ok, ac_f}), 8'({1'b1, ubc_pkg::AC_LVL3}), "ac write");
      i_host.wr(ubc_pkg::I2C_ADDR, ubc_pkg::OFS_DC_GAIN_STRAP, {5'h00, ubc_pkg::DC_80MV}, ok);
      i_host.rd(ubc_pkg::I2C_ADDR, ubc_pkg::OFS_DC_GAIN_STRAP, d, ok);
      check(8'(dc_f), {5'h00, ubc_pkg::DC_80MV}, "dc field");
      check(d, {5'h00, ubc_pkg::DC_80MV}, "dc read");
      i_host.rd(ubc_pkg::I2C_ADDR, 8'h02, d, ok);
      check(d, 8'h00, "unmapped read");
      i_host.wr(ubc_pkg::I2C_ADDR, ubc_pkg::OFS_CFG_HOLD, 8'h00, ok);
      wait_c(20);
      check(8'({hold, cd, comp}), 8'h03, "hold release");
      $display("test i2c done");
      tally_and_finish();
   end
endmodule : ubc_config_control_test
